// ### hw/gdu_regs_pkg.sv
// Package with port map, indices, field positions and codes of the graphics data unit
`default_nettype none
package gdu_regs_pkg;
   // ---------------------------------------------------------------
   // Port addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] PORT_SEG_HIGH = 16'h03cb;
   localparam logic [15:0] PORT_SEG_LOW = 16'h03cd;
   localparam logic [15:0] PORT_INDEX = 16'h03ce;
   localparam logic [15:0] PORT_DATA = 16'h03cf;
   // ---------------------------------------------------------------
   // Indexed register numbers
   // ---------------------------------------------------------------
   localparam logic [3:0] IDX_FILL_VALUE = 4'h0;
   localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
   localparam logic [3:0] IDX_MATCH_VALUE = 4'h2;
   localparam logic [3:0] IDX_ROTATE_FUNC = 4'h3;
   localparam logic [3:0] IDX_READ_PLANE = 4'h4;
   localparam logic [3:0] IDX_MODE = 4'h5;
   localparam logic [3:0] IDX_MISC = 4'h6;
   localparam logic [3:0] IDX_MATCH_ENABLE = 4'h7;
   localparam logic [3:0] IDX_BIT_MASK = 4'h8;
   localparam int NUM_INDEXED = 9;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int MODE_READ_BIT = 3;
   localparam int ROT_FUNC_LSB = 3;
   localparam int SEG_HIGH_RD_LSB = 4;
   localparam int SEG_LOW_RD_LSB = 4;
   localparam logic [7:0] LOW_NIBBLE_MASK = 8'h0f;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'hff;
   // ---------------------------------------------------------------
   // Logical function and write mode codes
   // ---------------------------------------------------------------
   localparam logic [1:0] FUNC_MOVE = 2'h0;
   localparam logic [1:0] FUNC_AND = 2'h1;
   localparam logic [1:0] FUNC_OR = 2'h2;
   localparam logic [1:0] FUNC_XOR = 2'h3;
   localparam logic [1:0] WMODE_0 = 2'h0;
   localparam logic [1:0] WMODE_1 = 2'h1;
   localparam logic [1:0] WMODE_2 = 2'h2;
   localparam logic [1:0] WMODE_3 = 2'h3;

   // Host port access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ioReq_t;

   // Controls handed to the write path
   typedef struct packed {
      logic [3:0] fillValue;
      logic [3:0] fillEnable;
      logic [1:0] writeMode;
   } fillCtrl_t;
endpackage
`default_nettype wire

// ### hw/plane_fill_select.sv
// Per-plane source byte selection with fill substitution
`default_nettype none
module plane_fill_select
   import gdu_regs_pkg::*;
(
   // Controls
   input wire fillCtrl_t ctrl,
   // Per-plane source bytes from the write mode logic
   input wire logic [31:0] modeSrc,
   // Per-plane source bytes to the logical function
   output logic [31:0] planeSrc
);
   // ---------------------------------------------------------------
   // Substitution per plane, suppressed in write mode 1
   // ---------------------------------------------------------------
   for (genvar p = 0; p < 4; p++) begin : gPlane
      logic useFill;
      assign useFill = ctrl.fillEnable[p] &&
         (ctrl.writeMode != WMODE_1);
      assign planeSrc[p*8 +: 8] = useFill ?
         {8{ctrl.fillValue[p]}} :
         modeSrc[p*8 +: 8];
   end
endmodule
`default_nettype wire

// ### hw/graphics_datapath_unit.sv
// Host port register bank and write/read data path of the graphics unit
`default_nettype none
// How it works
// - Nine indexed registers share the data port, chosen by the index.
// - 0..8: fill, enable, match, rotate, plane, mode, misc, care, mask.
// - Index register holds a 4-bit index; data port goes to that register.
// - Segment select high and low ports are both readable and writable.
// - Read window pointer is high bits 5:4 with low bits 7:4.
// - Write window pointer is high bits 1:0 with low bits 3:0.
// - Sequencer synchronous reset clears both segment select registers.
// - Fill value bit per plane replicates across the whole source byte.
// - Fill enable bit per plane turns substitution to 00 or ff.
// - Substituted byte still goes through logical function and bit mask.
// - Without substitution, write mode and bit mask set the written byte.
// - Substitution never applies in write mode 1.
// - Read mode 1 compares the 4-bit colour of each of eight pixels.
// - Compare read returns one bit per pixel, one where it matched.
// - Mode bit 3 selects plane byte read or compare result read.
// - Match plane enable bits exclude disabled planes from comparison.
module graphics_datapath_unit
   import gdu_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sequencer synchronous reset, active high while held
   input wire logic seqSyncReset,
   // Linear system selector from the display timing unit
   input wire logic linearSystem,
   // Host I/O port access
   input wire ioReq_t io,
   output logic [7:0] ioRdata,
   // Memory write data path
   input wire logic memWr,
   input wire logic [7:0] cpuData,
   input wire logic [31:0] latchData,
   output logic [31:0] memWdata,
   output logic memWrStb,
   // Memory read data path
   input wire logic memRd,
   input wire logic [31:0] memRdata,
   output logic [7:0] memRdResult,
   // Window pointers
   output logic [5:0] readWindowPointer,
   output logic [5:0] writeWindowPointer,
   // Register values for neighbouring blocks
   output logic [7:0] rotateFunc,
   output logic [7:0] miscReg
);
   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [7:0] segHigh_q, segHigh_d;
   logic [7:0] segLow_q, segLow_d;
   logic [3:0] index_q, index_d;
   logic [7:0] idxReg_q [NUM_INDEXED];
   logic [7:0] idxReg_d [NUM_INDEXED];
   logic [7:0] ioRdata_q, ioRdata_d;
   logic [31:0] memWdata_q, memWdata_d;
   logic memWrStb_q, memWrStb_d;
   logic [7:0] memRdResult_q, memRdResult_d;
   logic idxValid;
   logic [7:0] idxRead;

   // Indices past the last register reach nothing and read as zero
   assign idxValid = (index_q < 4'(NUM_INDEXED));

   // Writable bits per indexed register
   function automatic logic [7:0] wrMask(input int i);
      if (i == int'(IDX_FILL_VALUE) || i == int'(IDX_FILL_ENABLE) ||
          i == int'(IDX_MATCH_VALUE) || i == int'(IDX_MATCH_ENABLE)) begin
         return LOW_NIBBLE_MASK;
      end
      return 8'hff;
   endfunction

   // ---------------------------------------------------------------
   // Register next state
   // ---------------------------------------------------------------
   always_comb begin
      segHigh_d = segHigh_q;
      segLow_d = segLow_q;
      index_d = index_q;
      for (int i = 0; i < NUM_INDEXED; i++) begin
         idxReg_d[i] = idxReg_q[i];
      end
      if (io.wr) begin
         case (io.addr)
            PORT_SEG_HIGH: segHigh_d = io.wdata;
            PORT_SEG_LOW: segLow_d = io.wdata;
            PORT_INDEX: index_d = io.wdata[3:0];
            PORT_DATA: begin
               for (int i = 0; i < NUM_INDEXED; i++) begin
                  if (idxValid && index_q == 4'(i)) begin
                     idxReg_d[i] = io.wdata & wrMask(i);
                  end
               end
            end
            default: ;
         endcase
      end
      // Sequencer reset wins over a host write in the same cycle
      if (seqSyncReset) begin
         segHigh_d = REG_RESET;
         segLow_d = REG_RESET;
      end
   end

   // ---------------------------------------------------------------
   // Read answer
   // ---------------------------------------------------------------
   always_comb begin
      idxRead = 8'h00;
      for (int i = 0; i < NUM_INDEXED; i++) begin
         if (idxValid && index_q == 4'(i)) begin
            idxRead = idxReg_q[i];
         end
      end
      ioRdata_d = ioRdata_q;
      if (io.rd) begin
         case (io.addr)
            PORT_SEG_HIGH: ioRdata_d = segHigh_q;
            PORT_SEG_LOW: ioRdata_d = segLow_q;
            PORT_INDEX: ioRdata_d = {4'h0, index_q};
            PORT_DATA: ioRdata_d = idxRead;
            default: ioRdata_d = 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Window pointers
   // ---------------------------------------------------------------
   always_comb begin
      if (!linearSystem) begin
         readWindowPointer = {segHigh_q[SEG_HIGH_RD_LSB +: 2],
            segLow_q[SEG_LOW_RD_LSB +: 4]};
         writeWindowPointer = {segHigh_q[1:0], segLow_q[3:0]};
      end else begin
         readWindowPointer = 6'h00;
         writeWindowPointer = 6'h00;
      end
   end

   // ---------------------------------------------------------------
   // Write path
   // ---------------------------------------------------------------
   fillCtrl_t fill;
   logic [1:0] writeMode;
   logic [1:0] func;
   logic [2:0] rotCount;
   logic [7:0] rotated;
   logic [7:0] bitMask;
   logic [31:0] modeSrc;
   logic [31:0] planeSrc;

   assign writeMode = idxReg_q[IDX_MODE][1:0];
   assign func = idxReg_q[IDX_ROTATE_FUNC][ROT_FUNC_LSB +: 2];
   assign rotCount = idxReg_q[IDX_ROTATE_FUNC][2:0];
   // Circular right rotation: the doubled byte feeds bit 0 back to bit 7
   assign rotated = 8'(({cpuData, cpuData} >> rotCount));
   assign fill.fillValue = idxReg_q[IDX_FILL_VALUE][3:0];
   assign fill.fillEnable = (writeMode == WMODE_3) ? 4'hf :
      idxReg_q[IDX_FILL_ENABLE][3:0];
   assign fill.writeMode = writeMode;
   assign bitMask = (writeMode == WMODE_3) ?
      (rotated & idxReg_q[IDX_BIT_MASK]) : idxReg_q[IDX_BIT_MASK];

   always_comb begin
      for (int p = 0; p < 4; p++) begin
         modeSrc[p*8 +: 8] = (writeMode == WMODE_2) ?
            {8{cpuData[p]}} : rotated;
      end
   end

   plane_fill_select fillSel (
      .ctrl(fill),
      .modeSrc(modeSrc),
      .planeSrc(planeSrc)
   );

   always_comb begin
      logic [7:0] src;
      logic [7:0] lat;
      logic [7:0] alu;
      src = 8'h00;
      lat = 8'h00;
      alu = 8'h00;
      memWdata_d = memWdata_q;
      memWrStb_d = memWr;
      if (memWr) begin
         for (int p = 0; p < 4; p++) begin
            src = planeSrc[p*8 +: 8];
            lat = latchData[p*8 +: 8];
            case (func)
               FUNC_MOVE: alu = src;
               FUNC_AND: alu = src & lat;
               FUNC_OR: alu = src | lat;
               FUNC_XOR: alu = src ^ lat;
               default: alu = src;
            endcase
            if (writeMode == WMODE_1) begin
               memWdata_d[p*8 +: 8] = lat;
            end else begin
               memWdata_d[p*8 +: 8] = (alu & bitMask) |
                  (lat & ~bitMask);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Read path with colour compare
   // ---------------------------------------------------------------
   always_comb begin
      logic [3:0] care;
      logic [3:0] want;
      logic [1:0] plane;
      logic [3:0] pix;
      care = idxReg_q[IDX_MATCH_ENABLE][3:0];
      want = idxReg_q[IDX_MATCH_VALUE][3:0];
      plane = idxReg_q[IDX_READ_PLANE][1:0];
      pix = 4'h0;
      memRdResult_d = memRdResult_q;
      if (memRd) begin
         if (idxReg_q[IDX_MODE][MODE_READ_BIT]) begin
            // A plane left out of the care set always counts as a match
            for (int b = 0; b < 8; b++) begin
               pix = {memRdata[24+b], memRdata[16+b],
                  memRdata[8+b], memRdata[b]};
               memRdResult_d[b] =
                  (((pix ^ want) & care) == 4'h0);
            end
         end else begin
            memRdResult_d = memRdata[plane*8 +: 8];
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Port registers; the bit mask resets open so plain writes land
   always_ff @(posedge clk) begin
      if (rst) begin
         segHigh_q <= REG_RESET;
         segLow_q <= REG_RESET;
         index_q <= 4'h0;
         for (int i = 0; i < NUM_INDEXED; i++) begin
            idxReg_q[i] <= (i == int'(IDX_BIT_MASK)) ? MASK_RESET : REG_RESET;
         end
      end else begin
         segHigh_q <= segHigh_d;
         segLow_q <= segLow_d;
         index_q <= index_d;
         for (int i = 0; i < NUM_INDEXED; i++) begin
            idxReg_q[i] <= idxReg_d[i];
         end
      end
   end

   // Host read data holds until the next host read
   always_ff @(posedge clk) begin
      if (rst) begin
         ioRdata_q <= REG_RESET;
      end else begin
         ioRdata_q <= ioRdata_d;
      end
   end

   // Write data holds; the strobe marks the one cycle it is new
   always_ff @(posedge clk) begin
      if (rst) begin
         memWdata_q <= 32'h0000_0000;
         memWrStb_q <= 1'b0;
      end else begin
         memWdata_q <= memWdata_d;
         memWrStb_q <= memWrStb_d;
      end
   end

   // Memory read result holds until the next memory read
   always_ff @(posedge clk) begin
      if (rst) begin
         memRdResult_q <= REG_RESET;
      end else begin
         memRdResult_q <= memRdResult_d;
      end
   end

   assign ioRdata = ioRdata_q;
   assign memWdata = memWdata_q;
   assign memWrStb = memWrStb_q;
   assign memRdResult = memRdResult_q;
   assign rotateFunc = idxReg_q[IDX_ROTATE_FUNC];
   assign miscReg = idxReg_q[IDX_MISC];
endmodule
`default_nettype wire

// ### dv/gdu_props.sv
// Port relation checker for the graphics data unit register bank
`default_nettype none
module gdu_props
   import gdu_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Controls and host port
   input wire logic seqSyncReset,
   input wire logic linearSystem,
   input wire ioReq_t io,
   input wire logic [7:0] ioRdata,
   // Memory path
   input wire logic memWr,
   input wire logic memWrStb,
   input wire logic memRd,
   input wire logic [7:0] memRdResult,
   // Window pointers
   input wire logic [5:0] readWindowPointer,
   input wire logic [5:0] writeWindowPointer
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic segWr;
   assign segWr = io.wr &&
      (io.addr == PORT_SEG_HIGH || io.addr == PORT_SEG_LOW);
   sequence s_lowWr;
      io.wr && io.addr == PORT_SEG_LOW && !seqSyncReset && !linearSystem;
   endsequence
   sequence s_wrPulse;
      memWr ##1 !memWr;
   endsequence
   property p_segLow;
      s_lowWr ##1 !linearSystem |->
         {readWindowPointer[3:0], writeWindowPointer[3:0]} == $past(io.wdata);
   endproperty
   a_segLow: assert property (p_segLow)
      else $error("low segment wrong");
   property p_segKeep;
      !seqSyncReset && !segWr && !linearSystem ##1 !linearSystem |->
         $stable(readWindowPointer) && $stable(writeWindowPointer);
   endproperty
   a_segKeep: assert property (p_segKeep)
      else $error("pointer moved");
   property p_segClear;
      seqSyncReset |=>
         readWindowPointer == 6'h00 && writeWindowPointer == 6'h00;
   endproperty
   a_segClear: assert property (p_segClear) else $error("no clear");
   property p_linear;
      linearSystem |->
         readWindowPointer == 6'h00 && writeWindowPointer == 6'h00;
   endproperty
   a_linear: assert property (p_linear) else $error("linear pointer");
   property p_idxRd;
      io.rd && io.addr == PORT_INDEX |=> ioRdata[7:4] == 4'h0;
   endproperty
   a_idxRd: assert property (p_idxRd)
      else $error("index upper bits");
   property p_rdHold;
      !io.rd |=> $stable(ioRdata);
   endproperty
   a_rdHold: assert property (p_rdHold)
      else $error("read data moved");
   property p_stb;
      s_wrPulse |-> memWrStb ##1 !memWrStb;
   endproperty
   a_stb: assert property (p_stb) else $error("write strobe wrong");
   property p_memRdHold;
      !memRd |=> $stable(memRdResult);
   endproperty
   a_memRdHold: assert property (p_memRdHold)
      else $error("result moved");
endmodule
bind graphics_datapath_unit gdu_props i_gdu_props (.clk(clk), .rst(rst),
   .seqSyncReset(seqSyncReset), .linearSystem(linearSystem), .io(io),
   .ioRdata(ioRdata), .memWr(memWr), .memWrStb(memWrStb), .memRd(memRd),
   .memRdResult(memRdResult), .readWindowPointer(readWindowPointer),
   .writeWindowPointer(writeWindowPointer));
`default_nettype wire

// ### dv/gdu_host_model.sv
// Host model issuing I/O port reads and writes
`default_nettype none
module gdu_host_model
   import gdu_regs_pkg::*;
(
   // Clock
   input wire logic clk,
   // Host port
   output var ioReq_t io,
   input wire logic [7:0] ioRdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial io = '0;
   task automatic ioWrite(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      io = '{1'b0, 1'b1, a, d};
      @(posedge clk);
      #1;
      io = '{1'b0, 1'b0, ~a, ~d};
   endtask
   task automatic ioRead(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      io = '{1'b1, 1'b0, a, ~io.wdata};
      @(posedge clk);
      #1;
      d = ioRdata;
      io = '{1'b0, 1'b0, ~a, io.wdata};
   endtask
   // Index first, then the shared data port
   task automatic idxWrite(input logic [3:0] i, input logic [7:0] d);
      ioWrite(PORT_INDEX, {4'h0, i});
      ioWrite(PORT_DATA, d);
   endtask
   task automatic idxRead(input logic [3:0] i, output logic [7:0] d);
      ioWrite(PORT_INDEX, {4'h0, i});
      ioRead(PORT_DATA, d);
   endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the graphics unit register bank and data path
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import gdu_regs_pkg::*;
   logic clk = 1'b0, rst, seqSyncReset, linearSystem, memWr, memRd, memWrStb;
   logic [7:0] cpuData, ioRdata, memRdResult, rotateFunc, miscReg, v;
   logic [31:0] latchData, memWdata, memRdata;
   logic [5:0] readWindowPointer, writeWindowPointer;
   ioReq_t io;
   int errors = 0, total_checks = 0;
   always #2.5 clk = ~clk;
   graphics_datapath_unit i_graphics_datapath_unit (.clk(clk), .rst(rst),
      .seqSyncReset(seqSyncReset), .linearSystem(linearSystem), .io(io),
      .ioRdata(ioRdata), .memWr(memWr), .cpuData(cpuData),
      .latchData(latchData), .memWdata(memWdata), .memWrStb(memWrStb),
      .memRd(memRd), .memRdata(memRdata), .memRdResult(memRdResult),
      .readWindowPointer(readWindowPointer),
      .writeWindowPointer(writeWindowPointer), .rotateFunc(rotateFunc),
      .miscReg(miscReg));
   gdu_host_model i_gdu_host_model (.clk(clk), .io(io), .ioRdata(ioRdata));
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic memWrite(input logic [7:0] c, input logic [31:0] l, e);
      @(posedge clk);
      #1;
      memWr = 1'b1;
      cpuData = c;
      latchData = l;
      @(posedge clk);
      #1;
      memWr = 1'b0;
      cpuData = ~c;
      `CHK(memWrStb, 1'b1)
      `CHK(memWdata, e)
   endtask
   task automatic memRead(input logic [31:0] d, input logic [7:0] e);
      @(posedge clk);
      #1;
      memRd = 1'b1;
      memRdata = d;
      @(posedge clk);
      #1;
      memRd = 1'b0;
      memRdata = ~d;
      `CHK(memRdResult, e)
   endtask
   // Pixel k matches when every cared plane bit equals the match value
   function automatic logic [7:0] cmpExp(logic [31:0] d, logic [3:0] m, c);
      logic [7:0] r;
      r = 8'hff;
      for (int k = 0; k < 8; k++) begin
         for (int p = 0; p < 4; p++) begin
            if (c[p] && d[p * 8 + k] != m[p]) r[k] = 1'b0;
         end
      end
      return r;
   endfunction
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      finish_test();
   end
   initial begin
      rst = 1'b1;
      {seqSyncReset, linearSystem, memWr, memRd} = 4'h0;
      {cpuData, latchData, memRdata} = '0;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      for (int i = 0; i < NUM_INDEXED; i++) begin
         i_gdu_host_model.idxRead(4'(i), v);
         `CHK(v, i == 8 ? MASK_RESET : REG_RESET)
      end
      for (int i = 0; i < NUM_INDEXED; i++) begin
         i_gdu_host_model.idxWrite(4'(i), 8'hf0 | 8'(i));
      end
      for (int i = 0; i < NUM_INDEXED; i++) begin
         i_gdu_host_model.idxRead(4'(i), v);
         `CHK(v, i inside {0, 1, 2, 7} ? 8'(i) : 8'hf0 | 8'(i))
      end
      `CHK(rotateFunc, 8'hf3)
      `CHK(miscReg, 8'hf6)
      i_gdu_host_model.idxWrite(4'h9, 8'h0c);
      i_gdu_host_model.idxRead(4'h9, v);
      `CHK(v, 8'h00)
      i_gdu_host_model.idxRead(4'h1, v);
      `CHK(v, 8'h01)
      i_gdu_host_model.ioWrite(PORT_INDEX, 8'hf9);
      i_gdu_host_model.ioRead(PORT_INDEX, v);
      `CHK(v, 8'h09)
      i_gdu_host_model.ioWrite(PORT_SEG_HIGH, 8'h39);
      i_gdu_host_model.ioWrite(PORT_SEG_LOW, 8'hc6);
      `CHK(readWindowPointer, 6'h3c)
      `CHK(writeWindowPointer, 6'h16)
      i_gdu_host_model.ioRead(PORT_SEG_HIGH, v);
      `CHK(v, 8'h39)
      linearSystem = 1'b1;
      @(posedge clk);
      #1;
      `CHK(readWindowPointer, 6'h00)
      linearSystem = 1'b0;
      seqSyncReset = 1'b1;
      @(posedge clk);
      #1 seqSyncReset = 1'b0;
      `CHK(writeWindowPointer, 6'h00)
      i_gdu_host_model.ioRead(PORT_SEG_LOW, v);
      `CHK(v, 8'h00)
      i_gdu_host_model.idxWrite(IDX_BIT_MASK, 8'hff);
      i_gdu_host_model.idxWrite(IDX_ROTATE_FUNC, 8'h00);
      i_gdu_host_model.idxWrite(IDX_MODE, 8'h00);
      i_gdu_host_model.idxWrite(IDX_FILL_VALUE, 8'h05);
      i_gdu_host_model.idxWrite(IDX_FILL_ENABLE, 8'h03);
      memWrite(8'h3c, 32'h0f0f0f0f, 32'h3c3c00ff);
      i_gdu_host_model.idxWrite(IDX_ROTATE_FUNC, 8'h18);
      memWrite(8'h3c, 32'h0f0f0f0f, 32'h33330ff0);
      i_gdu_host_model.idxWrite(IDX_BIT_MASK, 8'hf0);
      memWrite(8'h3c, 32'h0f0f0f0f, 32'h3f3f0fff);
      i_gdu_host_model.idxWrite(IDX_MODE, 8'h01);
      memWrite(8'h3c, 32'h12345678, 32'h12345678);
      i_gdu_host_model.idxWrite(IDX_MODE, 8'h02);
      memWrite(8'h3c, 32'h0f0f0f0f, 32'hffff0fff);
      i_gdu_host_model.idxWrite(IDX_ROTATE_FUNC, 8'h01);
      i_gdu_host_model.idxWrite(IDX_MODE, 8'h03);
      memWrite(8'h3c, 32'h0f0f0f0f, 32'h0f1f0f1f);
      linearSystem = 1'b0;
      i_gdu_host_model.idxWrite(IDX_MODE, 8'h08);
      i_gdu_host_model.idxWrite(IDX_MATCH_VALUE, 8'h0a);
      i_gdu_host_model.idxWrite(IDX_MATCH_ENABLE, 8'h0f);
      memRead(32'ha5c3f00f, cmpExp(32'ha5c3f00f, 4'ha, 4'hf));
      i_gdu_host_model.idxWrite(IDX_MATCH_ENABLE, 8'h03);
      memRead(32'ha5c3f00f, cmpExp(32'ha5c3f00f, 4'ha, 4'h3));
      i_gdu_host_model.idxWrite(IDX_MODE, 8'h00);
      i_gdu_host_model.idxWrite(IDX_READ_PLANE, 8'h02);
      memRead(32'h44332211, 8'h33);
      finish_test();
   end
endmodule
`default_nettype wire
